/* File: iocal_pkg.sv */
// package: register map, field positions and reset values of the io calibration control block
package iocal_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_OFFSET      = 12'h000;
	localparam logic [11:0] CAL_STAT_OFFSET  = 12'h004;
	localparam int          ADDR_W           = 12;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int DLL_RST_BIT     = 20;
	localparam int CLKDIV_RST_BIT  = 19;
	localparam int VREF_SEL_BIT    = 18;
	localparam int VREF_LVL_HI     = 17;
	localparam int VREF_LVL_LO     = 16;
	localparam int READY_BIT       = 15;
	localparam int IBUF_PD_BIT     = 14;
	localparam int CLEAR_BIT       = 13;
	localparam int DN_P_BIT        = 12;
	localparam int DN_N_BIT        = 11;
	localparam int UP_P_BIT        = 10;
	localparam int UP_N_BIT        = 9;
	localparam int PSAVE_BIT       = 8;
	localparam int WRITABLE_HI     = 20;

	// ----------------------------------------------------------------
	// reset values and masks
	// ----------------------------------------------------------------
	localparam logic [31:0] CTRL_RESET    = 32'h0018_0000;
	localparam logic [31:0] WRITE_MASK    = 32'h001f_7f00;
	localparam logic [31:0] RSVD_MASK     = 32'hffe0_0000;

	// reference level codes
	localparam logic [1:0]  VREF_MID_A    = 2'h0;
	localparam logic [1:0]  VREF_LOW      = 2'h1;
	localparam logic [1:0]  VREF_HIGH     = 2'h2;
	localparam logic [1:0]  VREF_MID_B    = 2'h3;

	// reference level encodings for the analog trim (one-hot)
	localparam logic [2:0]  LVL_475       = 3'h1;
	localparam logic [2:0]  LVL_500       = 3'h2;
	localparam logic [2:0]  LVL_525       = 3'h4;

endpackage

/* File: iocal_sync.sv */
// two-flop synchroniser for levels entering from outside the pclk domain
`timescale 1ns/10ps
module iocal_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// level in and out
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	// the first stage is read only by the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule // iocal_sync

/* File: iocal_vref_decode.sv */
// decoder from the two-bit reference level code to a one-hot analog trim select
`timescale 1ns/10ps
module iocal_vref_decode (
	// code in
	input  wire logic [1:0] level_code,
	// trim out
	output logic      [2:0] level_onehot
);

	always_comb begin
		unique case (level_code)
			iocal_pkg::VREF_LOW:   level_onehot = iocal_pkg::LVL_475;
			iocal_pkg::VREF_HIGH:  level_onehot = iocal_pkg::LVL_525;
			iocal_pkg::VREF_MID_A,
			iocal_pkg::VREF_MID_B: level_onehot = iocal_pkg::LVL_500;
		endcase
	end

endmodule // iocal_vref_decode

/* File: iocal_ctrl.sv */
// apb register block controlling the io impedance calibration of the ddr interface
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/10ps

// ----------------------------------------------------------------
// register block
// ----------------------------------------------------------------
// Behaviour
// - bit 20 drives the delay loop reset, active low, reset value one.
// - bit 19 drives the io clock divider reset, active low, reset one.
// - bit 18 selects internal reference when one, external pad when zero.
// - bits 17:16 pick reference level: 01 low, 10 high, 00/11 midpoint.
// - bit 14 lets the phy receiver power-down reach the input buffers.
// - bit 13 low holds the calibration flops cleared; resets to zero.
// - bit 12 forces pfet drive down, bit 11 nfet drive down.
// - bit 10 forces pfet drive up, overriding computed setting.
// - register decodes in the system control space, not the memory controller.
// - bit 8 enables calibration power save mode.
module iocal_ctrl #(
	parameter int ADDR_W = iocal_pkg::ADDR_W
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// calibration engine status, asynchronous
	input  wire logic              cal_done,
	// phy receiver power-down request
	input  wire logic              phy_rx_powerdown,
	// controls to the io macro and calibration engine
	output logic                   delay_loop_reset_n,
	output logic                   io_clock_divider_reset_n,
	output logic                   internal_reference_select,
	output logic      [1:0]        reference_level_select,
	output logic      [2:0]        reference_level_trim,
	output logic                   input_buffer_powerdown,
	output logic                   calibration_clear_n,
	output logic                   force_pfet_drive_down,
	output logic                   force_nfet_drive_down,
	output logic                   force_pfet_drive_up,
	output logic                   force_nfet_drive_up,
	output logic                   calibration_power_save
);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
		hit = (a == ADDR_W'(off));
	endfunction

	logic        access;
	logic        ctrl_hit;
	logic        stat_hit;
	logic        mapped;
	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic [31:0] byte_mask;
	logic        ready_sync;
	logic        ibuf_pd_q;
	logic [31:0] rdata_d;

	// only the system-control-space offsets decode here
	assign access   = psel && penable;
	assign ctrl_hit = hit(paddr, iocal_pkg::CTRL_OFFSET);
	assign stat_hit = hit(paddr, iocal_pkg::CAL_STAT_OFFSET);
	assign mapped   = ctrl_hit || stat_hit;

	// zero wait states; unmapped or write to status answers with an error
	assign pready  = 1'b1;
	assign pslverr = access && (!mapped || (pwrite && stat_hit));

	// ----------------------------------------------------------------
	// calibration done crosses in from the analog engine
	// ----------------------------------------------------------------
	iocal_sync #(
		.W (1)
	) u_ready_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (cal_done),
		.sync_out (ready_sync)
	);

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_strb
			assign byte_mask[gb*8 +: 8] = {8{pstrb[gb]}};
		end
	endgenerate

	// reserved and read-only bits never store; lower engine fields are out of this block
	always_comb begin
		ctrl_d = ctrl_q;
		if (access && pwrite && ctrl_hit) begin
			ctrl_d = (ctrl_q & ~(byte_mask & iocal_pkg::WRITE_MASK))
			       | (pwdata & byte_mask & iocal_pkg::WRITE_MASK);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= iocal_pkg::CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ----------------------------------------------------------------
	// control outputs
	// ----------------------------------------------------------------
	assign delay_loop_reset_n        = ctrl_q[iocal_pkg::DLL_RST_BIT];
	assign io_clock_divider_reset_n  = ctrl_q[iocal_pkg::CLKDIV_RST_BIT];
	assign internal_reference_select = ctrl_q[iocal_pkg::VREF_SEL_BIT];
	assign reference_level_select    =
		ctrl_q[iocal_pkg::VREF_LVL_HI:iocal_pkg::VREF_LVL_LO];
	assign calibration_clear_n       = ctrl_q[iocal_pkg::CLEAR_BIT];
	assign force_pfet_drive_down     = ctrl_q[iocal_pkg::DN_P_BIT];
	assign force_nfet_drive_down     = ctrl_q[iocal_pkg::DN_N_BIT];
	assign force_pfet_drive_up       = ctrl_q[iocal_pkg::UP_P_BIT];
	assign force_nfet_drive_up       = ctrl_q[iocal_pkg::UP_N_BIT];
	assign calibration_power_save    = ctrl_q[iocal_pkg::PSAVE_BIT];

	iocal_vref_decode u_vref_decode (
		.level_code   (reference_level_select),
		.level_onehot (reference_level_trim)
	);

	// the phy request is registered so the buffer gate changes glitch free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ibuf_pd_q <= 1'b0;
		end else begin
			ibuf_pd_q <= ctrl_q[iocal_pkg::IBUF_PD_BIT] && phy_rx_powerdown;
		end
	end
	assign input_buffer_powerdown = ibuf_pd_q;

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// ready reads zero while clear is held, since the flops are cleared then
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (ctrl_hit) begin
			rdata_d = ctrl_q & iocal_pkg::WRITE_MASK;
			rdata_d[iocal_pkg::READY_BIT] = ready_sync && calibration_clear_n;
		end else if (stat_hit) begin
			rdata_d[0] = ready_sync && calibration_clear_n;
		end
	end

	assign prdata = (access && !pwrite) ? rdata_d : 32'h0000_0000;

endmodule // iocal_ctrl

/* File: iocal_ctrl_asserts.sv */
// checker: timing relations between apb writes and the calibration controls
`timescale 1ns/10ps
module iocal_ctrl_asserts (
	// apb side
	input wire logic        pclk, presetn, psel, penable, pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic [3:0]  pstrb,
	// controls
	input wire logic        phy_rx_powerdown, input_buffer_powerdown, delay_loop_reset_n,
	input wire logic        io_clock_divider_reset_n, internal_reference_select,
	input wire logic        calibration_clear_n, force_pfet_drive_up, calibration_power_save,
	input wire logic [1:0]  reference_level_select,
	input wire logic [2:0]  reference_level_trim
);
	// ----
	// properties
	// ----
	logic wr;
	assign wr = psel & penable & pwrite & (paddr == 12'h000);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	dll_reset_a: assert property (wr && pstrb[2]
		|=> delay_loop_reset_n == $past(pwdata[20])) else $error("delay loop reset wrong");
	div_reset_a: assert property (wr && pstrb[2]
		|=> io_clock_divider_reset_n == $past(pwdata[19])) else $error("divider reset wrong");
	vref_sel_a: assert property (wr && pstrb[2]
		|=> internal_reference_select == $past(pwdata[18])) else $error("reference select wrong");
	vref_trim_a: assert property (reference_level_trim ==
		(reference_level_select == 2'h1 ? 3'h1 : reference_level_select == 2'h2 ? 3'h4 : 3'h2))
		else $error("trim decode wrong");
	ready_read_a: assert property (psel && penable && !pwrite && paddr == 12'h000
		&& !calibration_clear_n |-> !prdata[15]) else $error("ready set while cleared");
	ibuf_gate_a: assert property (!phy_rx_powerdown |=> !input_buffer_powerdown)
		else $error("input buffer powered down without request");
	clear_hold_a: assert property (wr && pstrb[1]
		|=> calibration_clear_n == $past(pwdata[13])) else $error("clear wrong");
	force_up_a: assert property (wr && pstrb[1]
		|=> force_pfet_drive_up == $past(pwdata[10])) else $error("force up wrong");
	rsvd_zero_a: assert property (psel && penable && !pwrite
		|-> prdata[31:21] == 11'h000) else $error("reserved bits read nonzero");
	psave_a: assert property (wr && pstrb[1]
		|=> calibration_power_save == $past(pwdata[8])) else $error("power save wrong");
	cover property (wr && pstrb[2]);
	cover property (psel && penable && !pwrite && prdata[15]);
	cover property (input_buffer_powerdown);
endmodule // iocal_ctrl_asserts

/* File: test_iocal_ctrl.sv */
// testbench: register model against the io calibration control block
`timescale 1ns/10ps
module test_iocal_ctrl;
	// ----
	// signals
	// ----
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic        cal_done = 0, phy_rx_powerdown = 0, rdy, se;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, m, rd, wm;
	logic [3:0]  pstrb = '0;
	logic        pready, pslverr, delay_loop_reset_n, io_clock_divider_reset_n;
	logic        internal_reference_select, input_buffer_powerdown, calibration_clear_n;
	logic        force_pfet_drive_down, force_nfet_drive_down, force_pfet_drive_up;
	logic        force_nfet_drive_up, calibration_power_save;
	logic [1:0]  reference_level_select;
	logic [2:0]  reference_level_trim;
	int          err_count = 0, tests_run = 0, seed = 32, cyc = 0;
	iocal_ctrl iocal_ctrl_i (.*);
	always #2 pclk = ~pclk;
	task complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			complete_run;
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel   <= 1'h1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		pstrb  <= s;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		se = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask
	// model write: only enabled lanes of writable bits change
	task wrm(input logic [31:0] d, input logic [3:0] s);
		wm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & iocal_pkg::WRITE_MASK;
		m = (m & ~wm) | (d & wm);
		apb(1'h1, 12'h000, d, s);
		@(negedge pclk);
		chk("controls", {m[20:16], m[13:8]}, {delay_loop_reset_n, io_clock_divider_reset_n,
			internal_reference_select, reference_level_select, calibration_clear_n,
			force_pfet_drive_down, force_nfet_drive_down, force_pfet_drive_up,
			force_nfet_drive_up, calibration_power_save});
		chk("trim", m[17:16] == 2'h1 ? 3'h1 : m[17:16] == 2'h2 ? 3'h4 : 3'h2,
			reference_level_trim);
	endtask
	task rdc;
		apb(1'h0, 12'h000, '0, '0);
		chk("ctrl read", m | {16'h0, rdy, 15'h0}, rd);
		chk("ctrl error", 1'h0, se);
	endtask
	initial begin
		m = iocal_pkg::CTRL_RESET;
		rdy = 1'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'h1;
		rdc;
		repeat (20) begin
			// software keeps the reserved bits at zero on every write
			wrm($random(seed) & ~iocal_pkg::RSVD_MASK, $random(seed));
			rdc;
		end
		$display("test random writes done");
		for (int c = 0; c < 4; c++)
			wrm((m & ~32'h0003_0000) | (c << 16), 4'h4);
		$display("test reference levels done");
		wrm(m | 32'h0000_a000, 4'h2);
		rdc;
		@(posedge pclk) cal_done <= 1'h1;
		repeat (4) @(posedge pclk);
		rdy = 1'h1;
		rdc;
		wrm(m & ~32'h0000_2000, 4'h2);
		rdy = 1'h0;
		rdc;
		wrm(m | 32'h0000_2000, 4'h2);
		rdy = 1'h1;
		$display("test ready flag done");
		for (int b = 0; b < 4; b++) begin
			@(posedge pclk) phy_rx_powerdown <= b[0];
			wrm((m & ~32'h0000_4000) | (b[1] << 14), 4'h2);
			@(negedge pclk);
			chk("input buffer powerdown", b[0] & b[1], input_buffer_powerdown);
		end
		$display("test powerdown gate done");
		apb(1'h1, 12'h004, 32'hffff_ffff, 4'hf);
		chk("status write error", 1'h1, se);
		rdc;
		apb(1'h0, 12'h004, '0, '0);
		chk("status read", {31'h0, rdy}, rd);
		chk("status error", 1'h0, se);
		apb(1'h0, 12'h008, '0, '0);
		chk("unmapped data", 32'h0, rd);
		chk("unmapped error", 1'h1, se);
		$display("test decode done");
		complete_run;
	end
endmodule // test_iocal_ctrl
bind iocal_ctrl iocal_ctrl_asserts iocal_ctrl_asserts_i (.*);
